// *** hdl/dsc_defs.svh ***
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH

// Frame geometry
`define DSC_FRAME_BITS 24
`define DSC_CNT_LAST 5'h17
`define DSC_CODE_HI 19
`define DSC_CODE_LO 16
// Command codes (low nibble of the command byte)
`define DSC_CMD_NOP_LO 4'h0
`define DSC_CMD_WR_CTRL 4'h1
`define DSC_CMD_RD_CTRL 4'h2
`define DSC_CMD_LD_IN 4'h3
`define DSC_CMD_LD_BOTH 4'h4
`define DSC_CMD_LD_DAC 4'h5
`define DSC_CMD_WR_CLR 4'h6
`define DSC_CMD_RD_IN 4'h7
`define DSC_CMD_RD_DAC 4'h8
`define DSC_CMD_RD_CLR 4'h9
`define DSC_CMD_NOP_HI 4'hf
// Control register: D15..D5 writable, D4..D0 read as zero here
`define DSC_CTRL_WMASK 16'hffe0
`define DSC_REG_RESET 16'h0000
// Settling time after an output update
`define DSC_CLK_PERIOD_NS 40
`define DSC_UPDATE_WAIT_NS 5000
`define DSC_UPDATE_WAIT_CYC ((`DSC_UPDATE_WAIT_NS + `DSC_CLK_PERIOD_NS - 1) / `DSC_CLK_PERIOD_NS)
`endif

// *** hdl/dsc_pkg.sv ***
`include "dsc_defs.svh"
package dsc_pkg;
    // Command nibble decoding
    typedef enum logic [3:0] {
        DSC_NOP_LO = `DSC_CMD_NOP_LO,
        DSC_WR_CTRL = `DSC_CMD_WR_CTRL,
        DSC_RD_CTRL = `DSC_CMD_RD_CTRL,
        DSC_LD_IN = `DSC_CMD_LD_IN,
        DSC_LD_BOTH = `DSC_CMD_LD_BOTH,
        DSC_LD_DAC = `DSC_CMD_LD_DAC,
        DSC_WR_CLR = `DSC_CMD_WR_CLR,
        DSC_RD_IN = `DSC_CMD_RD_IN,
        DSC_RD_DAC = `DSC_CMD_RD_DAC,
        DSC_RD_CLR = `DSC_CMD_RD_CLR,
        DSC_NOP_HI = `DSC_CMD_NOP_HI
    } dsc_cmd_t;

    // One serial frame, first bit received in the top position
    typedef struct packed {
        logic [3:0] ignored;
        logic [3:0] code;
        logic [15:0] data;
    } dsc_frame_t;

    // Register set seen by the analog side
    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] input_code;
        logic [15:0] dac_code;
        logic [15:0] clear_code;
    } dsc_regs_t;
endpackage

// *** hdl/dsc_port.sv ***
`timescale 1ns/1ns
`include "dsc_defs.svh"
module dsc_port (
    // System clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Serial link from the bus master
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic din_in,
    output logic dout_out,
    output logic dout_oe_n_out,
    // Asynchronous output load pin
    input wire logic async_output_load_n_in,
    // Register contents and status
    output dsc_pkg::dsc_regs_t regs_out,
    output logic update_busy_out
);
    import dsc_pkg::*;

    //--------------------------------------------------------------
    // Helper functions
    //--------------------------------------------------------------
    // True for command codes that return data on the next frame
    function automatic logic is_read(input logic [3:0] code);
        is_read = (code == `DSC_CMD_RD_CTRL) || (code == `DSC_CMD_RD_IN) ||
                  (code == `DSC_CMD_RD_DAC) || (code == `DSC_CMD_RD_CLR);
    endfunction

    // True for command codes that change the output register
    function automatic logic is_dac_upd(input logic [3:0] code);
        is_dac_upd = (code == `DSC_CMD_LD_BOTH) || (code == `DSC_CMD_LD_DAC);
    endfunction

    //--------------------------------------------------------------
    // Link clock domain
    //--------------------------------------------------------------
    logic [1:0] srst_ff;
    logic srst;
    logic [23:0] shreg_ff;
    logic [4:0] bitcnt_ff;
    logic dout_ff;
    logic [15:0] rb_data_ff;

    // Reset carried onto the serial clock
    always_ff @(posedge sclk_in) begin
        srst_ff <= {srst_ff[0], sys_rst_in};
    end
    assign srst = srst_ff[1];

    // Bit position inside the current frame
    always_ff @(posedge sclk_in) begin
        if (srst) begin
            bitcnt_ff <= 5'h00;
        end else if (!cs_n_in) begin
            if (bitcnt_ff == `DSC_CNT_LAST) begin
                bitcnt_ff <= 5'h00;
            end else begin
                bitcnt_ff <= bitcnt_ff + 5'h01;
            end
        end
    end

    // Shift register; on a frame after a read the data part is replaced
    // by the requested register ahead of the first shift
    always_ff @(posedge sclk_in) begin
        if (srst) begin
            shreg_ff <= 24'h000000;
        end else if (!cs_n_in) begin
            if (bitcnt_ff == 5'h00 && is_read(shreg_ff[`DSC_CODE_HI:`DSC_CODE_LO])) begin
                shreg_ff <= {shreg_ff[22:16], rb_data_ff, din_in};
            end else begin
                shreg_ff <= {shreg_ff[22:0], din_in};
            end
        end
    end

    // Serial output taken from the top of the register; it also follows on
    // falling edges outside a frame, so the leading bit is already in place
    // when chip-select drops with the clock idling low; with it idling high, the first falling edge of the frame places it
    always_ff @(negedge sclk_in) begin
        if (srst) begin
            dout_ff <= 1'b0;
        end else begin
            dout_ff <= shreg_ff[23];
        end
    end
    assign dout_out = dout_ff;

    //--------------------------------------------------------------
    // Pin synchronizers in the system domain
    //--------------------------------------------------------------
    logic [2:0] cs_sync_ff;
    logic cs_lvl_ff;
    logic cs_rise;
    logic [2:0] ld_sync_ff;
    logic ld_lvl_ff;
    logic ld_fall;

    // Three stages; a change counts once the last two agree
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cs_sync_ff <= 3'h7;
            ld_sync_ff <= 3'h7;
        end else begin
            cs_sync_ff <= {cs_sync_ff[1:0], cs_n_in};
            ld_sync_ff <= {ld_sync_ff[1:0], async_output_load_n_in};
        end
    end

    // Filtered levels
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cs_lvl_ff <= 1'b1;
            ld_lvl_ff <= 1'b1;
        end else begin
            if (cs_sync_ff[1] == cs_sync_ff[2]) begin
                cs_lvl_ff <= cs_sync_ff[2];
            end
            if (ld_sync_ff[1] == ld_sync_ff[2]) begin
                ld_lvl_ff <= ld_sync_ff[2];
            end
        end
    end

    // Frame end and load pin events
    assign cs_rise = (cs_sync_ff[1] == cs_sync_ff[2]) && cs_sync_ff[2] && !cs_lvl_ff;
    assign ld_fall = (ld_sync_ff[1] == ld_sync_ff[2]) && !ld_sync_ff[2] && ld_lvl_ff;

    // Output driver enable follows the pin itself: the filtered level lags by
    // several system clocks, which would leave the first bits of a frame
    // undriven and keep the line driven after the frame has ended
    assign dout_oe_n_out = cs_n_in;

    //--------------------------------------------------------------
    // Command decode and registers
    //--------------------------------------------------------------
    dsc_frame_t frame;
    dsc_regs_t regs_ff;
    logic [6:0] busy_cnt_ff;
    logic busy_ff;

    // Shift register is still while chip-select is high
    assign frame = dsc_frame_t'(shreg_ff);

    // Control register
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            regs_ff.ctrl <= `DSC_REG_RESET;
        end else if (cs_rise && frame.code == `DSC_CMD_WR_CTRL) begin
            regs_ff.ctrl <= frame.data & `DSC_CTRL_WMASK;
        end
    end

    // Input holding register
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            regs_ff.input_code <= `DSC_REG_RESET;
        end else if (cs_rise && (frame.code == `DSC_CMD_LD_IN ||
                                 frame.code == `DSC_CMD_LD_BOTH)) begin
            regs_ff.input_code <= frame.data;
        end
    end

    // Output register; a load-both or copy frame commit wins over the load pin
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            regs_ff.dac_code <= `DSC_REG_RESET;
        end else if (cs_rise && frame.code == `DSC_CMD_LD_BOTH) begin
            regs_ff.dac_code <= frame.data;
        end else if (cs_rise && frame.code == `DSC_CMD_LD_DAC) begin
            regs_ff.dac_code <= regs_ff.input_code;
        end else if (ld_fall) begin
            regs_ff.dac_code <= regs_ff.input_code;
        end
    end

    // Clear register
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            regs_ff.clear_code <= `DSC_REG_RESET;
        end else if (cs_rise && frame.code == `DSC_CMD_WR_CLR) begin
            regs_ff.clear_code <= frame.data;
        end
    end
    assign regs_out = regs_ff;

    // Readback word, steady long before the next frame starts
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rb_data_ff <= 16'h0000;
        end else if (cs_rise) begin
            case (frame.code)
                DSC_RD_CTRL: rb_data_ff <= regs_ff.ctrl;
                DSC_RD_IN: rb_data_ff <= regs_ff.input_code;
                DSC_RD_DAC: rb_data_ff <= regs_ff.dac_code;
                DSC_RD_CLR: rb_data_ff <= regs_ff.clear_code;
                default: rb_data_ff <= rb_data_ff;
            endcase
        end
    end

    // Settling window after an output update
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            busy_cnt_ff <= 7'h00;
            busy_ff <= 1'b0;
        end else if ((cs_rise && is_dac_upd(frame.code)) || ld_fall) begin
            busy_cnt_ff <= 7'(`DSC_UPDATE_WAIT_CYC);
            busy_ff <= 1'b1;
        end else if (busy_cnt_ff != 7'h00) begin
            busy_cnt_ff <= busy_cnt_ff - 7'h01;
            busy_ff <= (busy_cnt_ff != 7'h01);
        end
    end
    assign update_busy_out = busy_ff;

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    chk_ctrl_write: assert property (
        cs_rise && frame.code == `DSC_CMD_WR_CTRL |=>
        regs_ff.ctrl == ($past(frame.data) & `DSC_CTRL_WMASK))
        else $error("control write not stored");

    chk_input_only: assert property (
        cs_rise && frame.code == `DSC_CMD_LD_IN |=>
        regs_ff.input_code == $past(frame.data) && $stable(regs_ff.dac_code))
        else $error("input-only load touched output register");

    chk_load_both: assert property (
        cs_rise && frame.code == `DSC_CMD_LD_BOTH |=>
        regs_ff.input_code == $past(frame.data) && regs_ff.dac_code == $past(frame.data))
        else $error("dual load mismatch");

    chk_copy_cmd: assert property (
        cs_rise && frame.code == `DSC_CMD_LD_DAC |=>
        regs_ff.dac_code == $past(regs_ff.input_code))
        else $error("copy command failed");

    chk_pin_copy: assert property (
        ld_fall && !cs_rise |=> regs_ff.dac_code == $past(regs_ff.input_code))
        else $error("load pin copy failed");

    chk_noop_hold: assert property (
        cs_rise && (frame.code == `DSC_CMD_NOP_LO || frame.code == `DSC_CMD_NOP_HI) && !ld_fall
        |=> $stable(regs_ff) && $stable(rb_data_ff))
        else $error("no-op changed state");

    chk_read_pick: assert property (
        cs_rise && frame.code == `DSC_CMD_RD_CLR |=> rb_data_ff == $past(regs_ff.clear_code))
        else $error("readback word wrong");

    chk_clear_write: assert property (
        cs_rise && frame.code == `DSC_CMD_WR_CLR |=> regs_ff.clear_code == $past(frame.data))
        else $error("clear write not stored");

    chk_no_commit: assert property (
        !cs_rise && !ld_fall |=> $stable(regs_ff))
        else $error("register changed without a commit");

    chk_float_idle: assert property (
        dout_oe_n_out == cs_n_in)
        else $error("output driven while deselected");

    chk_rise_sync: assert property (
        cs_rise |=> cs_lvl_ff ##1 cs_lvl_ff || !cs_sync_ff[2])
        else $error("chip-select level not tracked");

    chk_reset_clear: assert property (
        @(posedge clk_in) disable iff (1'b0)
        sys_rst_in |=> regs_ff == '0 && dout_oe_n_out && !update_busy_out)
        else $error("reset did not clear registers");

    chk_busy_window: assert property (
        $rose(busy_ff) |-> busy_ff [*8])
        else $error("settling window too short");

    // Cycles spent so far in the current settling window; saturates
    logic [6:0] busy_age_ff;
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            busy_age_ff <= 7'h00;
        end else if (!busy_ff) begin
            busy_age_ff <= 7'h00;
        end else if (busy_age_ff != 7'h7f) begin
            busy_age_ff <= busy_age_ff + 7'h01;
        end
    end

    chk_busy_full: assert property (
        $fell(busy_ff) |-> busy_age_ff >= 7'(`DSC_UPDATE_WAIT_CYC))
        else $error("settling window ended early");

    chk_pin_busy: assert property (
        ld_fall |=> busy_ff)
        else $error("load pin did not start settling window");

    //--------------------------------------------------------------
    // Link domain checks
    //--------------------------------------------------------------
    chk_read_subst: assert property (
        @(posedge sclk_in) disable iff (srst)
        !cs_n_in && bitcnt_ff == 5'h00 && is_read(shreg_ff[`DSC_CODE_HI:`DSC_CODE_LO]) |=>
        shreg_ff[23:1] == {$past(shreg_ff[22:16]), $past(rb_data_ff)})
        else $error("readback word not loaded into frame");

    chk_link_reset: assert property (
        @(posedge sclk_in) disable iff (1'b0)
        srst |=> bitcnt_ff == 5'h00 && shreg_ff == 24'h000000)
        else $error("link state not cleared by reset");

    chk_count_idle: assert property (
        @(posedge sclk_in) disable iff (srst)
        cs_n_in |=> $stable(bitcnt_ff))
        else $error("frame counter moved while deselected");

    chk_shift_in: assert property (
        @(posedge sclk_in) disable iff (srst)
        !cs_n_in && bitcnt_ff != 5'h00 |=>
        shreg_ff == {$past(shreg_ff[22:0]), $past(din_in)})
        else $error("shift register did not shift");

    chk_frame_count: assert property (
        @(posedge sclk_in) disable iff (srst)
        !cs_n_in && bitcnt_ff == `DSC_CNT_LAST |=> bitcnt_ff == 5'h00)
        else $error("frame counter did not wrap at 24");

    chk_dout_fall: assert property (
        @(negedge sclk_in) disable iff (srst)
        !cs_n_in |=> dout_out == $past(shreg_ff[23]))
        else $error("serial output not from register top");

    cov_read_ctrl: cover property (cs_rise && frame.code == `DSC_CMD_RD_CTRL);
    cov_load_both: cover property (cs_rise && frame.code == `DSC_CMD_LD_BOTH);
    cov_pin_load: cover property (ld_fall);
    cov_noop_hi: cover property (cs_rise && frame.code == `DSC_CMD_NOP_HI);
    cov_readback: cover property (@(posedge sclk_in) !cs_n_in && bitcnt_ff == 5'h00 &&
        is_read(shreg_ff[`DSC_CODE_HI:`DSC_CODE_LO]));
endmodule

// *** dv/dsc_mstr_model.sv ***
`timescale 1ns/1ns
module dsc_mstr_model #(
    parameter int HALF_NS = 50
) (
    // Serial lines towards the port
    output logic sclk_out,
    output logic cs_n_out,
    output logic din_out,
    // Lines back from the port
    input wire logic dout_in,
    input wire logic dout_oe_n_in
);
    // ------------------------------------------------------------
    // Idle state of the bus
    // ------------------------------------------------------------
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        din_out = 1'b0;
    end

    // Clock pulses with chip-select high, used around reset so the link side follows it
    task automatic spin();
        repeat (4) begin
            #(HALF_NS) sclk_out = 1'b1;
            #(HALF_NS) sclk_out = 1'b0;
        end
    endtask

    // One frame, MSB first; rx collects the port's output at each rising edge
    task automatic frame(input logic [23:0] tx, input logic mode1, output logic [23:0] rx);
        sclk_out = mode1;
        #(HALF_NS);
        cs_n_out = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sclk_out = 1'b0;
            din_out = tx[i];
            #(HALF_NS);
            rx[i] = dout_oe_n_in ? ~din_out : dout_in;
            sclk_out = 1'b1;
            #(HALF_NS);
        end
        sclk_out = mode1;
        din_out = ~din_out; // Released line shows no stale value
        #(HALF_NS);
        cs_n_out = 1'b1;
    endtask
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ns
`include "dsc_defs.svh"
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module tb_top;
    import dsc_pkg::*;
    logic clk_in;
    logic sys_rst_in;
    logic async_output_load_n_in;
    logic sclk;
    logic cs_n;
    logic din;
    logic dout_out;
    logic dout_oe_n_out;
    dsc_regs_t regs_out;
    logic update_busy_out;
    int err_total;
    int num_checks;

    // ------------------------------------------------------------
    // Clock, design and bus master
    // ------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    dsc_port dsc_port_i (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .sclk_in(sclk), .cs_n_in(cs_n),
        .din_in(din), .dout_out(dout_out), .dout_oe_n_out(dout_oe_n_out),
        .async_output_load_n_in(async_output_load_n_in), .regs_out(regs_out),
        .update_busy_out(update_busy_out)
    );

    // Link clock of 6 ns, with no phase relation to the system clock
    dsc_mstr_model #(.HALF_NS(3)) dsc_mstr_model_i (
        .sclk_out(sclk), .cs_n_out(cs_n), .din_out(din),
        .dout_in(dout_out), .dout_oe_n_in(dout_oe_n_out)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        if (err_total == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Frame then a gap long enough for the commit
    task automatic send(input logic [23:0] tx, input logic m1, output logic [23:0] rx);
        dsc_mstr_model_i.frame(tx, m1, rx);
        repeat (12) @(posedge clk_in);
    endtask

    // Bounded wait for the settling flag to drop
    task automatic wait_idle();
        int n;
        n = 0;
        while (update_busy_out !== 1'b0 && n < 300) begin
            @(posedge clk_in);
            n++;
        end
        if (n >= 300) begin
            err_total++;
            tally_and_finish();
        end
    endtask

    // Read command, then a no-op frame that carries the answer out
    task automatic read_back(input logic [3:0] code, input logic [15:0] exp, input string nm);
        logic [23:0] rx;
        send({4'h0, code, 16'h0000}, 1'b0, rx);
        send({4'h0, DSC_NOP_LO, 16'h0000}, 1'b0, rx);
        `CHK(nm, {4'h0, code, exp}, rx)
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic s_loads();
        logic [23:0] rx;
        send({4'ha, DSC_LD_IN, 16'ha5c3}, 1'b0, rx);
        `CHK("in_only", 32'ha5c3_0000, regs_out[47:16])
        `CHK("oe_idle", 1'b1, dout_oe_n_out)
        send({4'h5, DSC_LD_BOTH, 16'h1234}, 1'b1, rx);
        `CHK("both", 32'h1234_1234, regs_out[47:16])
        `CHK("busy", 1'b1, update_busy_out)
        wait_idle();
        send({4'h0, DSC_LD_IN, 16'h0f0f}, 1'b1, rx);
        `CHK("dac_kept", 16'h1234, regs_out.dac_code)
        send({4'h0, DSC_LD_DAC, 16'hffff}, 1'b0, rx);
        `CHK("copy", 32'h0f0f_0f0f, regs_out[47:16])
        wait_idle();
    endtask

    task automatic s_pin();
        logic [23:0] rx;
        send({4'h0, DSC_LD_IN, 16'h7777}, 1'b0, rx);
        @(posedge clk_in) async_output_load_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        async_output_load_n_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        `CHK("pin_load", 16'h7777, regs_out.dac_code)
        wait_idle();
    endtask

    task automatic s_regs();
        logic [23:0] rx;
        send({4'h0, DSC_WR_CTRL, 16'hffff}, 1'b0, rx);
        `CHK("ctrl", `DSC_CTRL_WMASK, regs_out.ctrl)
        send({4'h0, DSC_WR_CLR, 16'hbeef}, 1'b1, rx);
        `CHK("clear", 16'hbeef, regs_out.clear_code)
        read_back(DSC_RD_CTRL, `DSC_CTRL_WMASK, "rd_ctrl");
        read_back(DSC_RD_IN, 16'h7777, "rd_in");
        read_back(DSC_RD_DAC, 16'h7777, "rd_dac");
        read_back(DSC_RD_CLR, 16'hbeef, "rd_clr");
    endtask

    task automatic s_nops();
        logic [23:0] rx;
        logic [7:0] cmds [7];
        cmds = '{8'h30, 8'h3f, 8'ha0, 8'hbf, 8'hc0, 8'hdf, 8'hef};
        foreach (cmds[k]) begin
            send({cmds[k], 16'h5a5a}, 1'b0, rx);
            `CHK("no_change", 64'hffe0_7777_7777_beef, regs_out)
        end
        send({4'h0, DSC_NOP_HI, 16'h3c3c}, 1'b1, rx);
        send({4'h0, DSC_NOP_LO, 16'h0000}, 1'b0, rx);
        `CHK("pass_out", 24'h0f3c3c, rx)
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        err_total = 0;
        num_checks = 0;
        sys_rst_in = 1'b1;
        async_output_load_n_in = 1'b1;
        dsc_mstr_model_i.spin();
        repeat (12) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        // Link side only leaves reset on serial clock edges
        dsc_mstr_model_i.spin();
        repeat (2) @(posedge clk_in);
        `CHK("rst_regs", 64'h0, regs_out)
        `CHK("rst_oe", 1'b1, dout_oe_n_out)
        `CHK("rst_busy", 1'b0, update_busy_out)
        s_loads();
        s_pin();
        s_regs();
        s_nops();
        tally_and_finish();
    end
endmodule
